//--- shq_map.svh
// Constants for the control and event queue engine
`ifndef SHQ_MAP_SVH
`define SHQ_MAP_SVH
// ==========================================================
// Request types and task functions
`define SHQ_TYPE_TASK 32'h0000_0000
`define SHQ_TYPE_QUERY 32'h0000_0001
`define SHQ_TYPE_SUBSCRIBE 32'h0000_0002
`define SHQ_SUB_QUERY_SET 32'h0000_0007
// ==========================================================
// Response codes
`define SHQ_RESP_OK 8'h00
`define SHQ_RESP_BAD_TARGET 8'h03
`define SHQ_RESP_BUSY 8'h05
`define SHQ_RESP_TRANSPORT 8'h06
`define SHQ_RESP_TARGET_FAIL 8'h07
`define SHQ_RESP_NEXUS_FAIL 8'h08
`define SHQ_RESP_FAILURE 8'h09
`define SHQ_RESP_WRONG_UNIT 8'h0C
`define SHQ_RESP_COMPLETE 8'h00
`define SHQ_RESP_SUCCEEDED 8'h0A
`define SHQ_RESP_REJECTED 8'h0B
// ==========================================================
// Event masks and event codes
`define SHQ_EVT_POWER 32'h0000_0004
`define SHQ_EVT_MEDIA 32'h0000_0010
`define SHQ_EVT_MULTI_HOST 32'h0000_0020
`define SHQ_EVT_BUSY 32'h0000_0040
`define SHQ_EVT_NONE 32'h0000_0000
`define SHQ_EVT_RESET 32'h0000_0001
`define SHQ_EVT_ASYNC 32'h0000_0002
`define SHQ_LOST_BIT 31
// ==========================================================
// Reset reasons, sense data, sizes
`define SHQ_REASON_REMOVED 32'h0000_0000
`define SHQ_REASON_HARD 32'h0000_0001
`define SHQ_REASON_RESCAN 32'h0000_0002
`define SHQ_KEY_ILLEGAL 8'h05
`define SHQ_KEY_ATTENTION 8'h06
`define SHQ_ASC_REMOVED 8'h25
`define SHQ_ASC_RESET 8'h29
`define SHQ_ASC_RESCAN 8'h3F
`define SHQ_ASCQ_RESCAN 8'h0E
`define SHQ_ASCQ_ZERO 8'h00
`define SHQ_ADDR_LEAD 8'h01
`define SHQ_HOTPLUG_BIT 1
`define SHQ_CTRL_LEN 32'h0000_0001
`define SHQ_AN_LEN 32'h0000_0005
`define SHQ_EVT_LEN 32'h0000_0010
`define SHQ_EVT_INFO_BASE 32'h0000_0010
`define SHQ_UNITS 16
`endif

//--- shq_pkg.sv
// Types for the control and event queue engine
package shq_pkg;
   typedef enum logic [2:0] {
      SHQ_EV_IDLE = 3'b001,
      SHQ_EV_WAIT = 3'b010,
      SHQ_EV_DONE = 3'b100
   } shq_ev_state_t;
endpackage : shq_pkg

//--- shq_ctrl_event.sv
// Control queue interpreter and event queue filler
`timescale 1ns/1ps
`include "shq_map.svh"
// Summary of operation
// - Control requests start with 32-bit type; device writes common response byte.
// - Task management type 0; subtypes 0 to 7 select the function.
// - Task outcome written as complete 0, succeeded 10 or rejected 11.
// - Irrelevant fields ignored; unit number ignored for nexus-wide functions.
// - Task-referencing functions compare id against outstanding request ids.
// - Query type 1 returns supported subset of requested events.
// - Event masks: power 4, media 16, multi-host 32, busy 64.
// - Subscribe records events per unit and returns supported subset.
// - Query and subscribe use only common response codes.
// - Events without buffer may be dropped; no pending event storage.
// - Bit 31 of event word set after an event was lost.
// - Short buffer returned with code 0; lost-only record when buffer posted.
// - Transport reset event carries unit address and reason code.
// - Removed and rescan events only when hot-plug negotiated.
// - Reset conditions also reported as sense key and codes.
// - Async notice code 2 with reason masked by subscription.
// - Unit address: byte 1, target, two-byte unit, four zeros.
// - Largest event record size advertised as a fixed 16, whatever the negotiated features.
// - Feature bit 1 enables hot-plug reporting.
module shq_ctrl_event (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic [31:0] features_i,
   input wire logic [31:0] supported_events_i,
   input wire logic req_valid_i,
   input wire logic [31:0] req_type_i,
   input wire logic [31:0] req_subtype_i,
   input wire logic [63:0] req_unit_i,
   input wire logic [63:0] req_task_id_i,
   input wire logic [31:0] req_events_i,
   input wire logic [63:0] active_id_0_i,
   input wire logic [63:0] active_id_1_i,
   input wire logic [63:0] active_id_2_i,
   input wire logic [63:0] active_id_3_i,
   input wire logic [3:0] active_valid_i,
   input wire logic target_present_i,
   input wire logic unit_present_i,
   input wire logic device_busy_i,
   output logic req_ready_o,
   output logic ctrl_done_o,
   output logic [7:0] ctrl_response_o,
   output logic [31:0] ctrl_actual_o,
   output logic [31:0] ctrl_len_o,
   output logic [3:0] abort_match_o,
   output logic [2:0] task_action_o,
   output logic task_whole_nexus_o,
   input wire logic buf_posted_i,
   input wire logic [31:0] buf_size_i,
   input wire logic reset_evt_i,
   input wire logic [31:0] reset_reason_i,
   input wire logic [63:0] reset_unit_i,
   input wire logic async_evt_i,
   input wire logic [31:0] async_reason_i,
   input wire logic [63:0] async_unit_i,
   output logic evt_busy_o,
   output logic evt_done_o,
   output logic [31:0] evt_word_o,
   output logic [63:0] evt_unit_o,
   output logic [31:0] evt_reason_o,
   output logic [31:0] evt_len_o,
   output logic [31:0] event_info_size_o,
   output logic sense_valid_o,
   output logic [7:0] sense_key_o,
   output logic [7:0] sense_asc_o,
   output logic [7:0] sense_ascq_o
);
   // ==========================================================
   // Helpers
   function automatic logic [3:0] shq_unit_idx(input logic [63:0] unit);
      shq_unit_idx = unit[43:40];
   endfunction : shq_unit_idx

   function automatic logic shq_addr_ok(input logic [63:0] unit);
      shq_addr_ok = (unit[63:56] == `SHQ_ADDR_LEAD) && (unit[31:0] == 32'h0000_0000);
   endfunction : shq_addr_ok

   logic [31:0] sub_mask_reg [`SHQ_UNITS];
   logic hotplug;
   logic [31:0] known_mask;
   logic [31:0] actual;
   logic [3:0] id_hit;
   logic [7:0] resp_next;
   logic nexus_wide;
   logic refers_task;

   assign hotplug = features_i[`SHQ_HOTPLUG_BIT];
   assign known_mask = `SHQ_EVT_POWER | `SHQ_EVT_MEDIA | `SHQ_EVT_MULTI_HOST | `SHQ_EVT_BUSY;
   assign actual = req_events_i & supported_events_i & known_mask;
   assign req_ready_o = 1'b1;
   // Unit number is meaningless for a whole nexus reset
   assign nexus_wide = (req_subtype_i == 32'h0000_0004);
   assign refers_task = (req_subtype_i == 32'h0000_0000) || (req_subtype_i == 32'h0000_0006);
   assign id_hit = {active_valid_i[3] && (active_id_3_i == req_task_id_i),
                    active_valid_i[2] && (active_id_2_i == req_task_id_i),
                    active_valid_i[1] && (active_id_1_i == req_task_id_i),
                    active_valid_i[0] && (active_id_0_i == req_task_id_i)};
   assign event_info_size_o = `SHQ_EVT_INFO_BASE;

   // ==========================================================
   // Response selection
   always_comb begin
      resp_next = `SHQ_RESP_FAILURE;
      if (req_type_i == `SHQ_TYPE_TASK) begin
         if (req_subtype_i > `SHQ_SUB_QUERY_SET) begin
            resp_next = `SHQ_RESP_FAILURE;
         end else if (!shq_addr_ok(req_unit_i) || !target_present_i) begin
            resp_next = `SHQ_RESP_BAD_TARGET;
         end else if (!nexus_wide && !unit_present_i) begin
            resp_next = `SHQ_RESP_WRONG_UNIT;
         end else if (device_busy_i) begin
            resp_next = `SHQ_RESP_BUSY;
         end else if (req_subtype_i == 32'h0000_0006) begin
            resp_next = (|id_hit) ? `SHQ_RESP_SUCCEEDED : `SHQ_RESP_COMPLETE;
         end else if (req_subtype_i == `SHQ_SUB_QUERY_SET) begin
            resp_next = (|active_valid_i) ? `SHQ_RESP_SUCCEEDED : `SHQ_RESP_COMPLETE;
         end else if (req_subtype_i == 32'h0000_0002) begin
            // No auto contingent allegiance is kept, so clearing it is refused
            resp_next = `SHQ_RESP_REJECTED;
         end else begin
            resp_next = `SHQ_RESP_COMPLETE;
         end
      end else if ((req_type_i == `SHQ_TYPE_QUERY) || (req_type_i == `SHQ_TYPE_SUBSCRIBE)) begin
         if (!shq_addr_ok(req_unit_i) || !target_present_i) begin
            resp_next = `SHQ_RESP_BAD_TARGET;
         end else if (!unit_present_i) begin
            resp_next = `SHQ_RESP_WRONG_UNIT;
         end else begin
            resp_next = `SHQ_RESP_OK;
         end
      end
   end

   // ==========================================================
   // Control completion
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_done_o <= 1'b0;
         ctrl_response_o <= 8'h00;
         ctrl_actual_o <= 32'h0000_0000;
         ctrl_len_o <= 32'h0000_0000;
         abort_match_o <= 4'h0;
         task_action_o <= 3'h0;
         task_whole_nexus_o <= 1'b0;
      end else begin
         ctrl_done_o <= req_valid_i;
         abort_match_o <= 4'h0;
         if (req_valid_i) begin
            ctrl_response_o <= resp_next;
            ctrl_actual_o <= 32'h0000_0000;
            ctrl_len_o <= `SHQ_CTRL_LEN;
            if ((req_type_i != `SHQ_TYPE_TASK) && (resp_next == `SHQ_RESP_OK)) begin
               ctrl_actual_o <= actual;
               ctrl_len_o <= `SHQ_AN_LEN;
            end
            if ((req_type_i == `SHQ_TYPE_TASK) && (resp_next == `SHQ_RESP_COMPLETE)) begin
               abort_match_o <= refers_task ? id_hit : active_valid_i;
               task_action_o <= req_subtype_i[2:0];
               task_whole_nexus_o <= nexus_wide;
            end
         end
      end
   end

   // ==========================================================
   // Subscriptions per unit
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < `SHQ_UNITS; i++) begin
            sub_mask_reg[i] <= 32'h0000_0000;
         end
      end else if (req_valid_i && (req_type_i == `SHQ_TYPE_SUBSCRIBE)
                   && (resp_next == `SHQ_RESP_OK)) begin
         sub_mask_reg[shq_unit_idx(req_unit_i)] <= actual;
      end
   end

   // ==========================================================
   // Event queue
   shq_pkg::shq_ev_state_t ev_state_reg;
   logic lost_reg;
   logic buf_avail_reg;
   logic reset_allowed;
   logic [31:0] async_masked;
   logic want_reset;
   logic want_async;

   // Removal and rescan are suppressed without hot-plug
   assign reset_allowed = hotplug || (reset_reason_i == `SHQ_REASON_HARD);
   assign async_masked = async_reason_i & sub_mask_reg[shq_unit_idx(async_unit_i)];
   assign want_reset = reset_evt_i && reset_allowed;
   assign want_async = async_evt_i && (async_masked != 32'h0000_0000);
   assign evt_busy_o = (ev_state_reg != shq_pkg::SHQ_EV_IDLE);

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ev_state_reg <= shq_pkg::SHQ_EV_IDLE;
         buf_avail_reg <= 1'b0;
         lost_reg <= 1'b0;
         evt_done_o <= 1'b0;
         evt_word_o <= 32'h0000_0000;
         evt_unit_o <= 64'h0000_0000_0000_0000;
         evt_reason_o <= 32'h0000_0000;
         evt_len_o <= 32'h0000_0000;
      end else begin
         evt_done_o <= 1'b0;
         case (ev_state_reg)
            shq_pkg::SHQ_EV_IDLE: begin
               // An event in the posting cycle is dropped, so setting wins over clearing
               if (buf_posted_i && (buf_size_i < `SHQ_EVT_INFO_BASE)) begin
                  evt_word_o <= {lost_reg, 31'h0000_0000};
                  evt_len_o <= 32'h0000_0004;
                  lost_reg <= want_reset || want_async;
                  ev_state_reg <= shq_pkg::SHQ_EV_DONE;
               end else if (buf_posted_i && lost_reg) begin
                  evt_word_o <= `SHQ_EVT_NONE | 32'h8000_0000;
                  evt_len_o <= 32'h0000_0004;
                  lost_reg <= want_reset || want_async;
                  ev_state_reg <= shq_pkg::SHQ_EV_DONE;
               end else if (buf_posted_i) begin
                  if (want_reset || want_async) begin
                     lost_reg <= 1'b1;
                  end
                  buf_avail_reg <= 1'b1;
                  ev_state_reg <= shq_pkg::SHQ_EV_WAIT;
               end else if (want_reset || want_async) begin
                  lost_reg <= 1'b1;
               end
            end
            shq_pkg::SHQ_EV_WAIT: begin
               // One buffer held; driver keeps several posted
               if (want_reset) begin
                  evt_word_o <= `SHQ_EVT_RESET | {lost_reg, 31'h0000_0000};
                  evt_unit_o <= reset_unit_i;
                  evt_reason_o <= reset_reason_i;
                  evt_len_o <= `SHQ_EVT_LEN;
                  lost_reg <= want_async;
                  buf_avail_reg <= 1'b0;
                  ev_state_reg <= shq_pkg::SHQ_EV_DONE;
               end else if (want_async) begin
                  evt_word_o <= `SHQ_EVT_ASYNC | {lost_reg, 31'h0000_0000};
                  evt_unit_o <= async_unit_i;
                  evt_reason_o <= async_masked;
                  evt_len_o <= `SHQ_EVT_LEN;
                  lost_reg <= 1'b0;
                  buf_avail_reg <= 1'b0;
                  ev_state_reg <= shq_pkg::SHQ_EV_DONE;
               end
            end
            shq_pkg::SHQ_EV_DONE: begin
               evt_done_o <= 1'b1;
               if (want_reset || want_async) begin
                  lost_reg <= 1'b1;
               end
               ev_state_reg <= shq_pkg::SHQ_EV_IDLE;
            end
            default: begin
               ev_state_reg <= shq_pkg::SHQ_EV_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Sense data mirror of reset conditions
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sense_valid_o <= 1'b0;
         sense_key_o <= 8'h00;
         sense_asc_o <= 8'h00;
         sense_ascq_o <= 8'h00;
      end else begin
         sense_valid_o <= reset_evt_i;
         if (reset_evt_i) begin
            case (reset_reason_i)
               `SHQ_REASON_REMOVED: begin
                  sense_key_o <= `SHQ_KEY_ILLEGAL;
                  sense_asc_o <= `SHQ_ASC_REMOVED;
                  sense_ascq_o <= `SHQ_ASCQ_ZERO;
               end
               `SHQ_REASON_RESCAN: begin
                  sense_key_o <= `SHQ_KEY_ATTENTION;
                  sense_asc_o <= `SHQ_ASC_RESCAN;
                  sense_ascq_o <= `SHQ_ASCQ_RESCAN;
               end
               default: begin
                  sense_key_o <= `SHQ_KEY_ATTENTION;
                  sense_asc_o <= `SHQ_ASC_RESET;
                  sense_ascq_o <= `SHQ_ASCQ_ZERO;
               end
            endcase
         end
      end
   end
endmodule : shq_ctrl_event

//--- shq_ctrl_event_asserts.sv
// Port checker for the control and event queue engine
`timescale 1ns/1ps
module shq_ctrl_event_asserts (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic [31:0] features_i,
   input wire logic [31:0] supported_events_i,
   input wire logic req_valid_i,
   input wire logic [31:0] req_type_i,
   input wire logic [31:0] req_subtype_i,
   input wire logic [31:0] req_events_i,
   input wire logic req_ready_o,
   input wire logic ctrl_done_o,
   input wire logic [7:0] ctrl_response_o,
   input wire logic [31:0] ctrl_actual_o,
   input wire logic [31:0] ctrl_len_o,
   input wire logic buf_posted_i,
   input wire logic [31:0] buf_size_i,
   input wire logic reset_evt_i,
   input wire logic [31:0] reset_reason_i,
   input wire logic evt_busy_o,
   input wire logic evt_done_o,
   input wire logic [31:0] evt_word_o,
   input wire logic [31:0] evt_reason_o,
   input wire logic [31:0] evt_len_o,
   input wire logic [31:0] event_info_size_o,
   input wire logic sense_valid_o,
   input wire logic [7:0] sense_asc_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   // ==========================================================
   // Control queue
   property p_done; ctrl_done_o == $past(req_valid_i); endproperty
   a_done: assert property (p_done) else $error("done not one cycle after request");
   property p_unknown;
      req_valid_i && (req_type_i > 32'h2 || req_type_i == 32'h0 && req_subtype_i > 32'h7)
      |=> ctrl_response_o == 8'h09 && ctrl_len_o == 32'h1;
   endproperty
   a_unknown: assert property (p_unknown) else $error("unknown request not failed");
   property p_common;
      req_valid_i && req_type_i inside {32'h1, 32'h2} |=> ctrl_response_o inside {8'h0, 8'h3, 8'hC};
   endproperty
   a_common: assert property (p_common) else $error("query response not common");
   property p_task;
      req_valid_i && req_type_i == 32'h0 && req_subtype_i < 32'h8
      |=> ctrl_response_o inside {8'h0, 8'h3, 8'h5, 8'hA, 8'hB, 8'hC};
   endproperty
   a_task: assert property (p_task) else $error("task response out of set");
   property p_actual;
      req_valid_i && req_type_i == 32'h1 |=> ctrl_response_o != 8'h0 ||
      ctrl_actual_o == ($past(req_events_i) & $past(supported_events_i) & 32'h74);
   endproperty
   a_actual: assert property (p_actual) else $error("actual events wrong");
   // ==========================================================
   // Event queue and sense data
   property p_short;
      buf_posted_i && !evt_busy_o && buf_size_i < 32'h10
      |-> ##[1:3] (evt_done_o && evt_word_o[30:0] == 31'h0 && evt_len_o == 32'h4);
   endproperty
   a_short: assert property (p_short) else $error("short buffer not returned");
   property p_hot;
      evt_done_o && evt_word_o[30:0] == 31'h1 && !features_i[1] |-> evt_reason_o == 32'h1;
   endproperty
   a_hot: assert property (p_hot) else $error("plug event without feature");
   property p_sense;
      reset_evt_i |=> sense_valid_o && sense_asc_o == ($past(reset_reason_i) == 32'h0 ? 8'h25 :
      $past(reset_reason_i) == 32'h2 ? 8'h3F : 8'h29);
   endproperty
   a_sense: assert property (p_sense) else $error("sense code wrong");
   property p_const; event_info_size_o == 32'h10 && req_ready_o; endproperty
   a_const: assert property (p_const) else $error("record size or ready wrong");
endmodule : shq_ctrl_event_asserts
bind shq_ctrl_event shq_ctrl_event_asserts shq_ctrl_event_asserts_inst (.*);

//--- shq_guest_model.sv
// Guest driver model: posts event buffers, lists outstanding ids
`timescale 1ns/1ps
module shq_guest_model (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic post_i,
   input wire logic [31:0] size_i,
   output logic buf_posted_o,
   output logic [31:0] buf_size_o,
   output logic [63:0] active_id_0_o,
   output logic [63:0] active_id_1_o,
   output logic [63:0] active_id_2_o,
   output logic [63:0] active_id_3_o,
   output logic [3:0] active_valid_o
);
   // ==========================================================
   // Outstanding ids, every slot busy
   assign active_id_0_o = 64'h0000_0000_0000_00A0;
   assign active_id_1_o = 64'h0000_0000_0000_00A1;
   assign active_id_2_o = 64'h0000_0000_0000_00A2;
   assign active_id_3_o = 64'h0000_0000_0000_00A3;
   assign active_valid_o = 4'hF;
   // ==========================================================
   // Posting; size scrambles between posts so stale values show
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         buf_posted_o <= 1'b0;
         buf_size_o <= 32'h0;
      end else begin
         buf_posted_o <= post_i;
         buf_size_o <= post_i ? size_i : ~buf_size_o;
      end
   end
endmodule : shq_guest_model

//--- scsi_host_control_event_queues_test.sv
// Self-checking bench for the control and event queue engine
`timescale 1ns/1ps
`define SHQ_CHK(a, b, m) begin checks++; if ((a) !== (b)) begin n_errors++; \
   $display("BAD %0t %s", $time, m); end end
module scsi_host_control_event_queues_test;
   // ==========================================================
   // Signals
   localparam logic [63:0] UNIT = 64'h0101_0000_0000_0000;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic req_valid_i, target_present_i, unit_present_i, device_busy_i, buf_posted_i;
   logic reset_evt_i, async_evt_i, post, req_ready_o, ctrl_done_o, task_whole_nexus_o;
   logic evt_busy_o, evt_done_o, sense_valid_o;
   logic [2:0] task_action_o;
   logic [3:0] active_valid_i, abort_match_o;
   logic [7:0] ctrl_response_o, sense_key_o, sense_asc_o, sense_ascq_o;
   logic [31:0] features_i, supported_events_i, req_type_i, req_subtype_i, req_events_i, r;
   logic [31:0] buf_size_i, reset_reason_i, async_reason_i, size, ctrl_actual_o, ctrl_len_o;
   logic [31:0] evt_word_o, evt_reason_o, evt_len_o, event_info_size_o;
   logic [63:0] req_unit_i, req_task_id_i, reset_unit_i, async_unit_i, evt_unit_o;
   logic [63:0] active_id_0_i, active_id_1_i, active_id_2_i, active_id_3_i;
   logic [79:0] cq[$];
   logic [95:0] eq[$];
   logic [23:0] sq[$];
   logic [79:0] cx;
   logic [95:0] ex;
   logic [23:0] sx;
   integer n_errors = 0;
   integer checks = 0;
   integer seed = 32'hE3691D88;
   integer i;
   always #5 ref_clk_i = ~ref_clk_i;
   shq_ctrl_event shq_ctrl_event_inst (.*);
   shq_guest_model shq_guest_model_inst (.ref_clk_i, .sys_rst_i, .post_i(post), .size_i(size),
      .buf_posted_o(buf_posted_i), .buf_size_o(buf_size_i), .active_id_0_o(active_id_0_i),
      .active_id_1_o(active_id_1_i), .active_id_2_o(active_id_2_i),
      .active_id_3_o(active_id_3_i), .active_valid_o(active_valid_i));
   // ==========================================================
   // Result watcher: oldest note against each completion
   always @(posedge ref_clk_i) begin
      if (ctrl_done_o === 1'b1) begin
         cx = cq.pop_front();
         `SHQ_CHK(ctrl_response_o, cx[79:72], "response")
         `SHQ_CHK(ctrl_actual_o, cx[71:40], "actual events")
         `SHQ_CHK(ctrl_len_o, cx[39:8], "length")
         `SHQ_CHK(abort_match_o, cx[7:4], "abort match")
         if (cx[3]) begin
            `SHQ_CHK(task_action_o, cx[2:0], "task action")
            `SHQ_CHK(task_whole_nexus_o, cx[2:0] == 3'h4, "nexus scope")
         end
      end
      if (sense_valid_o === 1'b1) begin
         sx = sq.pop_front();
         `SHQ_CHK({sense_key_o, sense_asc_o, sense_ascq_o}, sx, "sense data")
      end
      if (evt_done_o === 1'b1) begin
         ex = eq.pop_front();
         `SHQ_CHK(evt_word_o, ex[95:64], "event word")
         `SHQ_CHK(evt_len_o, ex[31:0], "event length")
         if (ex[31:0] == 32'h10) begin
            `SHQ_CHK(evt_reason_o, ex[63:32], "reason")
            `SHQ_CHK(evt_unit_o, UNIT, "unit")
         end
      end
   end
   // ==========================================================
   // Drivers; back-to-back requests keep valid high
   task automatic ctrl(input logic [31:0] t, input logic [31:0] s, input logic [63:0] id,
      input logic [31:0] ev, input logic [7:0] rs, input logic [31:0] act);
      logic tk;
      logic [3:0] am;
      tk = (t == 32'h0) && (rs == 8'h00);
      // Partner's outstanding ids are 0xA0 to 0xA3, one per slot
      am = (s == 32'h0 || s == 32'h6) ? ((id[63:2] == 62'h28) ? 4'h1 << id[1:0] : 4'h0) : 4'hF;
      req_valid_i <= 1'b1;
      req_type_i <= t;
      req_subtype_i <= s;
      req_task_id_i <= id;
      req_events_i <= ev;
      cq.push_back({rs, act, (rs == 8'h0 && t != 32'h0) ? 32'h5 : 32'h1, tk ? am : 4'h0, tk,
         s[2:0]});
      @(posedge ref_clk_i);
   endtask : ctrl
   task automatic idle(input int n);
      req_valid_i <= 1'b0;
      post <= 1'b0;
      reset_evt_i <= 1'b0;
      async_evt_i <= 1'b0;
      repeat (n) @(posedge ref_clk_i);
   endtask : idle
   task automatic put(input logic [31:0] sz);
      post <= 1'b1;
      size <= sz;
      @(posedge ref_clk_i);
      idle(4);
   endtask : put
   task automatic fire(input logic rst, input logic [31:0] why);
      reset_evt_i <= rst;
      async_evt_i <= !rst;
      reset_reason_i <= why;
      async_reason_i <= why;
      if (rst) begin
         sq.push_back(why == 32'h0 ? 24'h05_25_00 : (why == 32'h2 ? 24'h06_3F_0E : 24'h06_29_00));
      end
      @(posedge ref_clk_i);
      idle(4);
   endtask : fire
   task automatic stop_test;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test
   // ==========================================================
   // Main sequence
   initial begin
      {req_valid_i, device_busy_i, reset_evt_i, async_evt_i, post} = 5'h0;
      {target_present_i, unit_present_i} = 2'h3;
      {features_i, req_type_i, req_subtype_i, req_events_i, size} = 160'h0;
      {reset_reason_i, async_reason_i, req_task_id_i} = 128'h0;
      {req_unit_i, reset_unit_i, async_unit_i} = {3{UNIT}};
      supported_events_i = $random(seed) | 32'h10;
      repeat (8) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge ref_clk_i);
      for (i = 0; i < 8; i++) begin
         ctrl(0, i, 64'hA1, 0, i == 2 ? 8'h0B : (i >= 6 ? 8'h0A : 8'h00), 0);
      end
      ctrl(0, 6, 64'hB7, 0, 8'h00, 0);
      ctrl(0, 8, 0, 0, 8'h09, 0);
      ctrl(5, 0, 0, 0, 8'h09, 0);
      target_present_i <= 1'b0;
      ctrl(1, 0, 0, 32'h10, 8'h03, 0);
      target_present_i <= 1'b1;
      unit_present_i <= 1'b0;
      ctrl(0, 5, 0, 0, 8'h0C, 0);
      ctrl(0, 4, 0, 0, 8'h00, 0);
      unit_present_i <= 1'b1;
      device_busy_i <= 1'b1;
      ctrl(0, 1, 0, 0, 8'h05, 0);
      device_busy_i <= 1'b0;
      for (i = 0; i < 6; i++) begin
         r = $random(seed);
         ctrl(1 + i % 2, 0, 0, r, 8'h00, r & supported_events_i & 32'h74);
      end
      ctrl(2, 0, 0, 32'h10, 8'h00, 32'h10);
      idle(3);
      $display("control tests done");
      r = $random(seed);
      eq.push_back({32'h0, 32'h0, 32'h4});
      put({28'h0, r[3:0]});
      fire(1, 1);
      eq.push_back({32'h8000_0000, 32'h0, 32'h4});
      put(32'h10);
      ctrl(1, 0, 0, 32'h10, 8'h00, 32'h10);
      idle(2);
      eq.push_back({32'h1, 32'h1, 32'h10});
      put(32'h10);
      `SHQ_CHK(evt_busy_o, 1'b1, "buffer not held")
      fire(1, 0);
      fire(1, 1);
      features_i <= 32'h2;
      eq.push_back({32'h1, 32'h2, 32'h10});
      put(32'h10);
      fire(1, 2);
      eq.push_back({32'h1, 32'h0, 32'h10});
      put(32'h10);
      fire(1, 0);
      eq.push_back({32'h2, 32'h10, 32'h10});
      put(32'h10);
      fire(0, 32'h30);
      $display("event tests done");
      `SHQ_CHK(cq.size() + eq.size() + sq.size(), 0, "completions missing")
      stop_test();
   end
endmodule : scsi_host_control_event_queues_test
